//--- fcpc_pkg.sv
package fcpc_pkg;
  // Register file addresses (12-bit register space)
  localparam logic [11:0] FCPC_ADDR_COMMAND = 12'hff8;
  localparam logic [11:0] FCPC_ADDR_PAGE = 12'hff9;
  // Command codes
  localparam logic [7:0] FCPC_CMD_RESET = 8'h00;
  localparam logic [7:0] FCPC_CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] FCPC_CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] FCPC_CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] FCPC_CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] FCPC_CMD_PROT_SEL = 8'h5e;
  // Reset values and erased byte value
  localparam logic [7:0] FCPC_PAGE_RESET = 8'h00;
  localparam logic [7:0] FCPC_PROT_RESET = 8'h00;
  localparam logic [7:0] FCPC_ERASED_BYTE = 8'hff;
  // Page select field layout
  localparam int FCPC_INFO_BIT = 7;
  localparam int FCPC_PAGE_MSB = 6;
  // Flash address layout: page is bits 15:9, sector is bits 15:13
  localparam int FCPC_ADDR_W = 16;
  localparam int FCPC_PAGE_LSB_ADDR = 9;
  localparam int FCPC_SECT_LSB_ADDR = 13;
  localparam logic [15:0] FCPC_INFO_BASE = 16'hfe00;
  // Status codes
  localparam logic [5:0] FCPC_ST_LOCKED = 6'h00;
  localparam logic [5:0] FCPC_ST_UNLOCK1 = 6'h01;
  localparam logic [5:0] FCPC_ST_UNLOCK2 = 6'h02;
  localparam logic [5:0] FCPC_ST_UNLOCKED = 6'h03;
  localparam logic [5:0] FCPC_ST_PROT_SEL = 6'h04;
  localparam logic [5:0] FCPC_ST_PROGRAM = 6'h08;
  localparam logic [5:0] FCPC_ST_PAGE_ERASE = 6'h10;
  localparam logic [5:0] FCPC_ST_MASS_ERASE = 6'h20;

  typedef enum logic [2:0] {
    FCPC_LOCKED = 3'b000,
    FCPC_GOT_FIRST = 3'b001,
    FCPC_GOT_SECOND = 3'b010,
    FCPC_UNLOCKED = 3'b011,
    FCPC_PROT_SELECTED = 3'b100,
    FCPC_PROGRAMMING = 3'b101,
    FCPC_PAGE_ERASING = 3'b110,
    FCPC_MASS_ERASING = 3'b111
  } fcpc_state_t;
endpackage

//--- fcpc_ctrl.sv
`timescale 1ns/1ps
module fcpc_ctrl
  import fcpc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dbg_access,
  input wire logic wp_option,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic op_done,
  output logic flash_prog,
  output logic flash_page_erase,
  output logic flash_mass_erase,
  output logic [15:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_info_sel,
  output logic flash_busy
);

  fcpc_state_t state, next_state;
  logic [7:0] page_selection, next_page_selection;
  logic [7:0] sector_lock_bits, next_sector_lock_bits;
  logic page_rewritten, next_page_rewritten;
  logic [7:0] reg_rdata_q, next_reg_rdata;
  logic flash_prog_q, next_flash_prog;
  logic page_erase_q, next_page_erase;
  logic mass_erase_q, next_mass_erase;
  logic [15:0] flash_addr_q, next_flash_addr;
  logic [7:0] flash_wdata_q, next_flash_wdata;
  logic info_sel_q, next_info_sel;
  logic busy_q, next_busy;

  logic cmd_wr;
  logic page_wr;
  logic [7:0] command_code;
  logic ready;
  logic page_blocked;
  logic addr_blocked;
  logic in_page;

  function automatic logic sector_locked(input logic [7:0] bits, input logic [6:0] page);
    logic [2:0] idx;
    idx = page[FCPC_PAGE_MSB -: 3];
    sector_locked = bits[idx];
  endfunction

  function automatic logic [5:0] status_code(input fcpc_state_t s);
    case (s)
      FCPC_GOT_FIRST: status_code = FCPC_ST_UNLOCK1;
      FCPC_GOT_SECOND: status_code = FCPC_ST_UNLOCK2;
      FCPC_UNLOCKED: status_code = FCPC_ST_UNLOCKED;
      FCPC_PROT_SELECTED: status_code = FCPC_ST_PROT_SEL;
      FCPC_PROGRAMMING: status_code = FCPC_ST_PROGRAM;
      FCPC_PAGE_ERASING: status_code = FCPC_ST_PAGE_ERASE;
      FCPC_MASS_ERASING: status_code = FCPC_ST_MASS_ERASE;
      default: status_code = FCPC_ST_LOCKED;
    endcase
  endfunction

  always_comb begin
    command_code = reg_wdata;
    if (reg_wr && reg_addr == FCPC_ADDR_COMMAND) begin
      cmd_wr = 1'b1;
      page_wr = 1'b0;
    end else if (reg_wr && reg_addr == FCPC_ADDR_PAGE) begin
      cmd_wr = 1'b0;
      page_wr = 1'b1;
    end else begin
      cmd_wr = 1'b0;
      page_wr = 1'b0;
    end
    ready = (state == FCPC_UNLOCKED) && (page_rewritten || dbg_access);
    page_blocked = !dbg_access && (wp_option || sector_locked(sector_lock_bits, page_selection[FCPC_PAGE_MSB:0]));
    addr_blocked = !dbg_access && (wp_option || sector_locked(sector_lock_bits,
                   mem_addr[FCPC_ADDR_W-1:FCPC_PAGE_LSB_ADDR]));
    in_page = mem_addr[FCPC_ADDR_W-1:FCPC_PAGE_LSB_ADDR] == page_selection[FCPC_PAGE_MSB:0];
  end

  always_comb begin
    next_state = state;
    next_page_selection = page_selection;
    next_sector_lock_bits = sector_lock_bits;
    next_page_rewritten = page_rewritten;
    next_flash_prog = 1'b0;
    next_page_erase = 1'b0;
    next_mass_erase = 1'b0;
    next_flash_addr = flash_addr_q;
    next_flash_wdata = flash_wdata_q;
    next_info_sel = page_selection[FCPC_INFO_BIT];
    case (state)
      FCPC_PROGRAMMING: begin
        if (op_done) begin
          next_state = FCPC_UNLOCKED;
        end
      end
      FCPC_PAGE_ERASING: begin
        if (op_done) begin
          next_state = FCPC_LOCKED;
          next_page_rewritten = 1'b0;
        end
      end
      FCPC_MASS_ERASING: begin
        if (op_done) begin
          next_state = FCPC_LOCKED;
          next_page_rewritten = 1'b0;
        end
      end
      default: begin
        if (cmd_wr) begin
          next_page_rewritten = 1'b0;
          if (command_code == FCPC_CMD_UNLOCK1 && state == FCPC_LOCKED) begin
            next_state = FCPC_GOT_FIRST;
          end else if (command_code == FCPC_CMD_UNLOCK2 && state == FCPC_GOT_FIRST) begin
            next_state = dbg_access ? FCPC_UNLOCKED : FCPC_GOT_SECOND;
          end else if (command_code == FCPC_CMD_PROT_SEL && state == FCPC_LOCKED) begin
            next_state = FCPC_PROT_SELECTED;
          end else if (command_code == FCPC_CMD_PAGE_ERASE && ready && !page_blocked) begin
            next_state = FCPC_PAGE_ERASING;
            next_page_erase = 1'b1;
            next_flash_addr = {page_selection[FCPC_PAGE_MSB:0], {FCPC_PAGE_LSB_ADDR{1'b0}}};
            next_flash_wdata = FCPC_ERASED_BYTE;
          end else if (command_code == FCPC_CMD_MASS_ERASE && ready && dbg_access) begin
            next_state = FCPC_MASS_ERASING;
            next_mass_erase = 1'b1;
            next_flash_wdata = FCPC_ERASED_BYTE;
          end else begin
            next_state = FCPC_LOCKED;
          end
          if (command_code == FCPC_CMD_PAGE_ERASE && next_state == FCPC_PAGE_ERASING) begin
            next_page_rewritten = 1'b0;
          end else if (next_state == FCPC_UNLOCKED) begin
            next_page_rewritten = page_rewritten;
          end
        end else if (page_wr && state == FCPC_PROT_SELECTED) begin
          if (dbg_access) begin
            next_sector_lock_bits = reg_wdata;
          end else begin
            next_sector_lock_bits = sector_lock_bits | reg_wdata;
          end
        end else if (page_wr) begin
          if (state == FCPC_LOCKED) begin
            next_page_selection = reg_wdata;
          end else if (state == FCPC_GOT_SECOND) begin
            // Rewrite must match or the sequence is broken
            if (reg_wdata == page_selection) begin
              next_state = FCPC_UNLOCKED;
              next_page_rewritten = 1'b1;
            end else begin
              next_state = FCPC_LOCKED;
            end
          end else if (state == FCPC_UNLOCKED && dbg_access) begin
            next_page_selection = reg_wdata;
          end else begin
            next_state = FCPC_LOCKED;
            next_page_rewritten = 1'b0;
          end
        end else if (mem_wr && ready) begin
          if ((dbg_access || in_page) && !addr_blocked) begin
            next_state = FCPC_PROGRAMMING;
            next_flash_prog = 1'b1;
            next_flash_addr = dbg_access ? mem_addr
                            : {page_selection[FCPC_PAGE_MSB:0], mem_addr[FCPC_PAGE_LSB_ADDR-1:0]};
            next_flash_wdata = mem_wdata;
          end
        end
      end
    endcase
    if (next_flash_prog) begin
      next_info_sel = page_selection[FCPC_INFO_BIT] && (next_flash_addr >= FCPC_INFO_BASE);
    end
    next_busy = next_state == FCPC_PROGRAMMING || next_state == FCPC_PAGE_ERASING ||
                next_state == FCPC_MASS_ERASING;
    next_reg_rdata = 8'h00;
    if (reg_rd && reg_addr == FCPC_ADDR_COMMAND) begin
      next_reg_rdata = {2'b00, status_code(state)};
    end else if (reg_rd && reg_addr == FCPC_ADDR_PAGE) begin
      next_reg_rdata = (state == FCPC_PROT_SELECTED) ? sector_lock_bits : page_selection;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= FCPC_LOCKED;
      page_selection <= FCPC_PAGE_RESET;
      sector_lock_bits <= FCPC_PROT_RESET;
      page_rewritten <= 1'b0;
      reg_rdata_q <= 8'h00;
      flash_prog_q <= 1'b0;
      page_erase_q <= 1'b0;
      mass_erase_q <= 1'b0;
      flash_addr_q <= 16'h0000;
      flash_wdata_q <= 8'h00;
      info_sel_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state <= next_state;
      page_selection <= next_page_selection;
      sector_lock_bits <= next_sector_lock_bits;
      page_rewritten <= next_page_rewritten;
      reg_rdata_q <= next_reg_rdata;
      flash_prog_q <= next_flash_prog;
      page_erase_q <= next_page_erase;
      mass_erase_q <= next_mass_erase;
      flash_addr_q <= next_flash_addr;
      flash_wdata_q <= next_flash_wdata;
      info_sel_q <= next_info_sel;
      busy_q <= next_busy;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign flash_prog = flash_prog_q;
  assign flash_page_erase = page_erase_q;
  assign flash_mass_erase = mass_erase_q;
  assign flash_addr = flash_addr_q;
  assign flash_wdata = flash_wdata_q;
  assign flash_info_sel = info_sel_q;
  assign flash_busy = busy_q;

endmodule // fcpc_ctrl

//--- fcpc_flash_model.sv
`timescale 1ns/1ps
module fcpc_flash_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] delay,
  output logic op_done
);
  logic [3:0] cnt;
  // Delay of zero would never finish; bench keeps it at one or more
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt <= 4'h0;
    end else if (start) begin
      cnt <= delay;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  assign op_done = (cnt == 4'h1);
endmodule // fcpc_flash_model

//--- fcpc_ctrl_checker.sv
`timescale 1ns/1ps
module fcpc_ctrl_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dbg_access,
  input wire logic wp_option,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic op_done,
  input wire logic flash_prog,
  input wire logic flash_page_erase,
  input wire logic flash_mass_erase,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_mass_debug_only: assert property (
    flash_mass_erase |-> $past(dbg_access && reg_wr && reg_wdata == 8'h63)) else $error("mass erase without cause");
  chk_erase_cmd: assert property (
    flash_page_erase |-> $past(reg_wr && reg_addr == 12'hff8 && reg_wdata == 8'h95)) else $error("stray page erase");
  chk_prog_data: assert property (
    flash_prog |-> $past(mem_wr) && flash_wdata == $past(mem_wdata)) else $error("program data wrong");
  chk_wp_user: assert property (
    flash_prog && !$past(dbg_access) |-> !$past(wp_option)) else $error("user program past write protect");
  chk_start_busy: assert property (
    flash_prog || flash_page_erase || flash_mass_erase |-> flash_busy) else $error("operation not busy");
  chk_busy_end: assert property (
    op_done && flash_busy |=> !flash_busy) else $error("busy after done");
  chk_status_rsvd: assert property (
    reg_rd && reg_addr == 12'hff8 |=> reg_rdata[7:6] == 2'b00) else $error("reserved status bits set");
  chk_idle_rdata: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data without read");
  cov_prog: cover property (flash_prog);
  cov_page_erase: cover property (flash_page_erase);
  cov_mass_erase: cover property (flash_mass_erase);
endmodule // fcpc_ctrl_checker
bind fcpc_ctrl fcpc_ctrl_checker u_chk (.ref_clk, .rst, .dbg_access, .wp_option, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .mem_wr, .mem_wdata, .op_done, .flash_prog, .flash_page_erase, .flash_mass_erase,
  .flash_wdata, .flash_busy);

//--- fcpc_ctrl_tb.sv
`timescale 1ns/1ps
module fcpc_ctrl_tb;
  import fcpc_pkg::*;
  logic ref_clk = 0, rst = 1, dbg_access = 0, wp_option = 0, reg_wr = 0, reg_rd = 0, mem_wr = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, mem_wdata = 0, reg_rdata, flash_wdata;
  logic [15:0] mem_addr = 0, flash_addr;
  logic op_done, flash_prog, flash_page_erase, flash_mass_erase, flash_info_sel, flash_busy;
  logic [3:0] dly = 4'h1;
  int failures = 0, num_checks = 0, ms = 0, mpage = 0, mprot = 0;
  fcpc_ctrl dut (.ref_clk, .rst, .dbg_access, .wp_option, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .mem_wr, .mem_addr, .mem_wdata, .op_done, .flash_prog, .flash_page_erase, .flash_mass_erase, .flash_addr,
    .flash_wdata, .flash_info_sel, .flash_busy);
  fcpc_flash_model fm (.ref_clk, .rst, .start(flash_prog | flash_page_erase | flash_mass_erase), .delay(dly),
    .op_done);
  initial forever #10 ref_clk = ~ref_clk;
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 40 && flash_busy !== 1'b0; k++) tick();
    if (flash_busy !== 1'b0) begin
      failures++;
      $display("mismatch flash_busy expected 0 seen %b", flash_busy);
      test_done();
    end
  endtask
  function automatic logic blocked(int a);
    return !dbg_access && (wp_option || mprot[a[15:13]]);
  endfunction
  // Bench model of the unlock machine; a is 0 for command, 1 for page
  task automatic wr(bit a, logic [7:0] v);
    logic ep, em;
    int nx;
    ep = 0;
    em = 0;
    nx = 0;
    if (!a) begin
      if (v == FCPC_CMD_UNLOCK1 && ms == 0) nx = 1;
      else if (v == FCPC_CMD_UNLOCK2 && ms == 1) nx = dbg_access ? 3 : 2;
      else if (v == FCPC_CMD_PROT_SEL && ms == 0) nx = 4;
      else if (v == FCPC_CMD_PAGE_ERASE && ms == 3) ep = !blocked(mpage << 9);
      else if (v == FCPC_CMD_MASS_ERASE && ms == 3) em = dbg_access;
      // Any other code, or a listed one out of order, relocks
      ms = nx;
    end else if (ms == 4) mprot = dbg_access ? v : mprot | v;
    else if (ms == 2) ms = (v == mpage) ? 3 : 0;
    else if (ms == 0 || (ms == 3 && dbg_access)) mpage = v;
    else ms = 0;
    reg_addr = a ? FCPC_ADDR_PAGE : FCPC_ADDR_COMMAND;
    reg_wdata = v;
    reg_wr = 1;
    tick();
    reg_wr = 0;
    chk("page_erase", ep, flash_page_erase);
    chk("mass_erase", em, flash_mass_erase);
    if (ep) chk("erase_addr", {mpage[6:0], 9'h000}, flash_addr);
    if (ep || em) chk("erase_data", FCPC_ERASED_BYTE, flash_wdata);
    // Idle cycle so the next call never re-raises the strobe in this step
    tick();
    if (ep || em) wait_idle();
  endtask
  task automatic rd(bit a, string n);
    reg_addr = a ? FCPC_ADDR_PAGE : FCPC_ADDR_COMMAND;
    reg_rd = 1;
    tick();
    reg_rd = 0;
    chk(n, !a ? ms : (ms == 4 ? mprot : mpage), reg_rdata);
    tick();
  endtask
  task automatic mw(logic [15:0] a, logic [7:0] d);
    logic ok;
    ok = ms == 3 && (dbg_access || (!blocked(a) && a[15:9] == mpage[6:0]));
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1;
    tick();
    mem_wr = 0;
    chk("prog", ok, flash_prog);
    if (ok) begin
      chk("addr", a, flash_addr);
      chk("data", d, flash_wdata);
      chk("info", mpage[7] && a >= FCPC_INFO_BASE, flash_info_sel);
      chk("busy", 1'b1, flash_busy);
      reg_addr = FCPC_ADDR_COMMAND;
      reg_rd = 1;
      tick();
      reg_rd = 0;
      chk("status_prog", FCPC_ST_PROGRAM, reg_rdata);
      wait_idle();
    end else begin
      tick();
    end
  endtask
  task automatic unlock(logic [7:0] p);
    wr(0, FCPC_CMD_RESET);
    wr(1, p);
    wr(0, FCPC_CMD_UNLOCK1);
    rd(0, "status_first");
    wr(0, FCPC_CMD_UNLOCK2);
    rd(0, "status_second");
    if (!dbg_access) wr(1, p);
    rd(0, "status_unlocked");
  endtask
  initial begin
    void'($urandom(32'he46198b7));
    repeat (10) tick();
    rst = 0;
    rd(0, "status_reset");
    rd(1, "page_reset");
    $display("test reset done");
    unlock(8'h05);
    for (int n = 0; n < 6; n++) begin
      dly = 4'($urandom_range(8, 1));
      mw({7'h05, 9'($urandom)}, 8'($urandom));
      mw({7'h06, 9'($urandom)}, 8'($urandom));
    end
    wr(1, 8'h06);
    rd(0, "relock_page");
    $display("test user program done");
    wr(0, FCPC_CMD_RESET);
    wr(1, 8'h07);
    wr(0, FCPC_CMD_PROT_SEL);
    rd(0, "status_prot");
    wr(1, 8'h02);
    wr(1, 8'h01);
    rd(1, "sector_bits");
    wr(0, FCPC_CMD_RESET);
    rd(1, "page_back");
    unlock(8'h12);
    mw(16'h2410, 8'h3c);
    wr(0, FCPC_CMD_PAGE_ERASE);
    unlock(8'h25);
    wr(0, FCPC_CMD_PAGE_ERASE);
    rd(0, "erase_relock");
    wp_option = 1;
    unlock(8'h25);
    mw(16'h4a00, 8'h5a);
    wr(0, FCPC_CMD_MASS_ERASE);
    rd(0, "mass_user");
    wr(0, FCPC_CMD_UNLOCK1);
    wr(0, FCPC_CMD_UNLOCK1);
    rd(0, "double_first");
    $display("test protection done");
    dbg_access = 1;
    wr(0, FCPC_CMD_RESET);
    wr(0, FCPC_CMD_PROT_SEL);
    wr(1, 8'h01);
    rd(1, "sector_clear");
    unlock(8'h80);
    wr(1, 8'h81);
    rd(1, "page_debug");
    mw(16'hfe10, 8'($urandom));
    mw(16'h0130, 8'($urandom));
    wr(0, FCPC_CMD_MASS_ERASE);
    wr(0, FCPC_CMD_RESET);
    dbg_access = 0;
    wp_option = 0;
    $display("test debug done");
    test_done();
  end
endmodule // fcpc_ctrl_tb
